// ### design/stm_defines.svh
// constants for the serial time message formatter
`ifndef STM_DEFINES_SVH
`define STM_DEFINES_SVH
`define STM_CLK_HZ 25000000
`define STM_OFF_CTRL 12'h000
`define STM_OFF_TIME 12'h004
`define STM_OFF_ZONE 12'h008
`define STM_OFF_STAT 12'h00c
`define STM_OFF_IRQ 12'h010
`define STM_OFF_MASK 12'h014
`define STM_OFF_FAULT 12'h018
`define STM_CH_CR 8'h0d
`define STM_CH_LF 8'h0a
`define STM_CH_SP 8'h20
`define STM_CH_QM 8'h3f
`define STM_CH_COLON 8'h3a
`define STM_CH_ZERO 8'h30
`define STM_CH_T 8'h54
`define STM_CH_Z 8'h5a
`define STM_CH_EQ 8'h3d
`define STM_CH_S 8'h53
`define STM_CH_I 8'h49
`define STM_CH_D 8'h44
`define STM_CH_O 8'h4f
`define STM_MSG_LEN 5'd25
`define STM_MERIT_BEST 4'd4
`define STM_MERIT_UNSYNC 4'd9
`define STM_HOLD_SECONDS 12'd600
`define STM_FAULT_SECONDS 12'd3600
`define STM_DIV_57600 16'd434
`define STM_DIV_19200 16'd1302
`define STM_DIV_9600 16'd2604
`define STM_DIV_4800 16'd5208
`define STM_PAR_NONE 2'd0
`define STM_PAR_ODD 2'd1
`define STM_PAR_EVEN 2'd2
`define STM_IRQ_MSG 0
`define STM_IRQ_ALARM 1
`define STM_IRQ_FAULT 2
`endif

// ### design/stm_formatter.sv
// serial time message formatter with apb registers and uart transmitter
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "stm_defines.svh"
////////////////////////////////////////////////////////////////////////
// Overview of operation
// - message order CR LF Q DDD time DST TZ CRLF
// - locked quality character is space
// - unsynchronized quality character is question mark
// - colon separated two digit hh mm ss
// - three digit day before time
// - one DST letter S I D O before zone
// - zone text TZ= plus 00..23
// - CR 0x0d and LF 0x0a both ends
// - leading CR starts on the second tick
// - merit code kept between 4 and 9
// - code 9 unsynchronized, also never locked
// - lost reference raises code gradually
// - fault indicator after one unsynchronized hour
// - timeout bit set in fault status
// - alarm on lost lock or hardware fault
// - on-time character early, output starts automatically
// - four baud rates, odd even none parity
module stm_formatter (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_pps,
  input wire logic i_ref_locked,
  input wire logic i_hw_fault,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_txd,
  output logic o_alarm,
  output logic o_fault_led,
  output logic o_irq
);
  import stm_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  logic [1:0] baud_sel;
  logic [1:0] parity_sel;
  logic [1:0] dst_sel;
  logic [4:0] zone;
  logic [8:0] day;
  logic [4:0] hour;
  logic [5:0] minute;
  logic [5:0] second;
  logic [3:0] merit;
  logic ever_locked;
  logic [11:0] hold_cnt;
  logic [11:0] unsync_cnt;
  logic fault_to;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] irq_event;
  logic alarm_q;
  logic wr_en;
  logic rd_en;
  stm_tx_e tx_state;
  logic [4:0] char_idx;
  logic [2:0] bit_idx;
  logic [15:0] baud_cnt;
  logic [15:0] baud_div;
  stm_char_t shreg;
  stm_char_t next_char;
  logic par_acc;
  logic msg_done;
  logic [8:0] day_l;
  logic [4:0] hour_l;
  logic [5:0] minute_l;
  logic [5:0] second_l;
  logic [1:0] dst_l;
  logic [4:0] zone_l;
  logic quality_locked;

  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && i_penable && !i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;

  function automatic stm_char_t digit(input logic [9:0] v);
    digit = `STM_CH_ZERO + stm_char_t'(v % 10'd10);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register writes; time registers are loaded by software each second
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      baud_sel <= 2'h0;
      parity_sel <= `STM_PAR_NONE;
      dst_sel <= 2'h0;
      zone <= 5'h00;
      day <= 9'h001;
      hour <= 5'h00;
      minute <= 6'h00;
      second <= 6'h00;
      irq_mask <= 3'h0;
    end else if (wr_en) begin
      if (i_paddr == `STM_OFF_CTRL) begin
        baud_sel <= i_pwdata[1:0];
        parity_sel <= (i_pwdata[3:2] == 2'h3) ? `STM_PAR_NONE : i_pwdata[3:2];
        dst_sel <= i_pwdata[5:4];
      end else if (i_paddr == `STM_OFF_TIME) begin
        day <= i_pwdata[24:16];
        hour <= i_pwdata[15:11];
        minute <= i_pwdata[10:5];
        second <= {1'b0, i_pwdata[4:0]};
      end else if (i_paddr == `STM_OFF_ZONE) begin
        zone <= (i_pwdata[4:0] > 5'd23) ? 5'd23 : i_pwdata[4:0];
        second <= i_pwdata[13:8];
      end else if (i_paddr == `STM_OFF_MASK) begin
        irq_mask <= i_pwdata[2:0];
      end
    end
  end

  always_comb begin
    o_prdata = 32'h0;
    if (!rd_en) begin
      o_prdata = 32'h0;
    end else if (i_paddr == `STM_OFF_CTRL) begin
      o_prdata = {26'h0, dst_sel, parity_sel, baud_sel};
    end else if (i_paddr == `STM_OFF_TIME) begin
      o_prdata = {7'h0, day, hour, minute, 5'h0};
    end else if (i_paddr == `STM_OFF_ZONE) begin
      o_prdata = {18'h0, second, 3'h0, zone};
    end else if (i_paddr == `STM_OFF_STAT) begin
      o_prdata = {24'h0, ever_locked, o_fault_led, o_alarm, 1'b0, merit};
    end else if (i_paddr == `STM_OFF_IRQ) begin
      o_prdata = {29'h0, irq_stat};
    end else if (i_paddr == `STM_OFF_MASK) begin
      o_prdata = {29'h0, irq_mask};
    end else if (i_paddr == `STM_OFF_FAULT) begin
      o_prdata = {31'h0, fault_to};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // merit tracking, hold count stepped once per second, merit once per hold interval
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      merit <= `STM_MERIT_UNSYNC;
      ever_locked <= 1'b0;
      hold_cnt <= 12'h000;
    end else if (i_ref_locked) begin
      merit <= `STM_MERIT_BEST;
      ever_locked <= 1'b1;
      hold_cnt <= 12'h000;
    end else if (!ever_locked) begin
      merit <= `STM_MERIT_UNSYNC;
    end else if (i_pps && merit != `STM_MERIT_UNSYNC) begin
      // degrade one step per hold interval instead of jumping straight to 9
      if (hold_cnt == `STM_HOLD_SECONDS - 12'd1) begin
        hold_cnt <= 12'h000;
        merit <= merit + 4'd1;
      end else begin
        hold_cnt <= hold_cnt + 12'd1;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      unsync_cnt <= 12'h000;
      fault_to <= 1'b0;
    end else if (merit != `STM_MERIT_UNSYNC) begin
      unsync_cnt <= 12'h000;
      fault_to <= 1'b0;
    end else if (i_pps && !fault_to) begin
      if (unsync_cnt == `STM_FAULT_SECONDS - 12'd1) begin
        fault_to <= 1'b1;
      end else begin
        unsync_cnt <= unsync_cnt + 12'd1;
      end
    end
  end

  assign o_fault_led = fault_to;
  assign quality_locked = (merit < `STM_MERIT_UNSYNC);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_alarm <= 1'b0;
      alarm_q <= 1'b0;
    end else begin
      o_alarm <= (ever_locked && !i_ref_locked) || i_hw_fault;
      alarm_q <= o_alarm;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear, set wins
  assign irq_event[`STM_IRQ_MSG] = msg_done;
  assign irq_event[`STM_IRQ_ALARM] = o_alarm && !alarm_q;
  // same condition that sets fault_to, so the event fires on the setting tick
  assign irq_event[`STM_IRQ_FAULT] = merit == `STM_MERIT_UNSYNC && i_pps && !fault_to
    && unsync_cnt == `STM_FAULT_SECONDS - 12'd1;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_irq
      always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
          irq_stat[gi] <= 1'b0;
        end else if (irq_event[gi]) begin
          irq_stat[gi] <= 1'b1;
        end else if (wr_en && i_paddr == `STM_OFF_IRQ && i_pwdata[gi]) begin
          irq_stat[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign o_irq = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////
  // message characters, time, dst and zone fields latched at the second tick; quality from live merit
  always_comb begin
    next_char = `STM_CH_CR;
    case (char_idx)
      5'd0: next_char = `STM_CH_CR;
      5'd1: next_char = `STM_CH_LF;
      5'd2: next_char = quality_locked ? `STM_CH_SP : `STM_CH_QM;
      5'd3: next_char = `STM_CH_SP;
      5'd4: next_char = digit(10'(day_l) / 10'd100);
      5'd5: next_char = digit(10'(day_l) / 10'd10);
      5'd6: next_char = digit(10'(day_l));
      5'd7: next_char = `STM_CH_SP;
      5'd8: next_char = digit(10'(hour_l) / 10'd10);
      5'd9: next_char = digit(10'(hour_l));
      5'd10: next_char = `STM_CH_COLON;
      5'd11: next_char = digit(10'(minute_l) / 10'd10);
      5'd12: next_char = digit(10'(minute_l));
      5'd13: next_char = `STM_CH_COLON;
      5'd14: next_char = digit(10'(second_l) / 10'd10);
      5'd15: next_char = digit(10'(second_l));
      5'd16: next_char = `STM_CH_SP;
      5'd17: begin
        case (dst_l)
          2'd0: next_char = `STM_CH_S;
          2'd1: next_char = `STM_CH_I;
          2'd2: next_char = `STM_CH_D;
          default: next_char = `STM_CH_O;
        endcase
      end
      5'd18: next_char = `STM_CH_T;
      5'd19: next_char = `STM_CH_Z;
      5'd20: next_char = `STM_CH_EQ;
      5'd21: next_char = digit(10'(zone_l) / 10'd10);
      5'd22: next_char = digit(10'(zone_l));
      5'd23: next_char = `STM_CH_CR;
      5'd24: next_char = `STM_CH_LF;
      default: next_char = `STM_CH_LF;
    endcase
  end

  always_comb begin
    baud_div = `STM_DIV_57600;
    case (baud_sel)
      2'd0: baud_div = `STM_DIV_57600;
      2'd1: baud_div = `STM_DIV_19200;
      2'd2: baud_div = `STM_DIV_9600;
      default: baud_div = `STM_DIV_4800;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // uart: a tick aborts nothing; the message must fit in the second
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      tx_state <= STM_IDLE;
      char_idx <= 5'd0;
      bit_idx <= 3'd0;
      baud_cnt <= 16'h0000;
      shreg <= 8'hff;
      par_acc <= 1'b0;
      o_txd <= 1'b1;
      msg_done <= 1'b0;
      day_l <= 9'h001;
      hour_l <= 5'h00;
      minute_l <= 6'h00;
      second_l <= 6'h00;
      dst_l <= 2'h0;
      zone_l <= 5'h00;
    end else begin
      msg_done <= 1'b0;
      case (tx_state)
        STM_IDLE: begin
          o_txd <= 1'b1;
          if (i_pps) begin
            // starts on first tick, no software enable needed
            day_l <= day;
            hour_l <= hour;
            minute_l <= minute;
            second_l <= second;
            dst_l <= dst_sel;
            zone_l <= zone;
            char_idx <= 5'd0;
            baud_cnt <= 16'h0000;
            tx_state <= STM_START;
            o_txd <= 1'b0;
          end
        end
        default: begin
          if (baud_cnt != baud_div - 16'd1) begin
            baud_cnt <= baud_cnt + 16'd1;
          end else begin
            baud_cnt <= 16'h0000;
            case (tx_state)
              STM_START: begin
                shreg <= next_char;
                par_acc <= ^next_char;
                o_txd <= next_char[0];
                bit_idx <= 3'd0;
                tx_state <= STM_DATA;
              end
              STM_DATA: begin
                if (bit_idx == 3'd7) begin
                  if (parity_sel == `STM_PAR_NONE) begin
                    o_txd <= 1'b1;
                    tx_state <= STM_STOP;
                  end else begin
                    o_txd <= (parity_sel == `STM_PAR_ODD) ? !par_acc : par_acc;
                    tx_state <= STM_PARITY;
                  end
                end else begin
                  bit_idx <= bit_idx + 3'd1;
                  o_txd <= shreg[bit_idx + 3'd1];
                end
              end
              STM_PARITY: begin
                o_txd <= 1'b1;
                tx_state <= STM_STOP;
              end
              default: begin
                if (char_idx == `STM_MSG_LEN - 5'd1) begin
                  msg_done <= 1'b1;
                  tx_state <= STM_IDLE;
                end else begin
                  char_idx <= char_idx + 5'd1;
                  o_txd <= 1'b0;
                  tx_state <= STM_START;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_cr_on_tick: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (tx_state == STM_IDLE && i_pps) |=> (!o_txd && char_idx == 5'd0))
    else $error("leading start bit not on tick");
  a_merit_range: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    merit >= `STM_MERIT_BEST && merit <= `STM_MERIT_UNSYNC)
    else $error("merit out of range");
  a_never_locked: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !ever_locked |-> merit == `STM_MERIT_UNSYNC)
    else $error("merit not 9 before lock");
  a_gradual_rise: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!i_ref_locked && ever_locked) |=> merit <= $past(merit) + 4'd1)
    else $error("merit jumped");
  a_fault_cause: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(fault_to) |-> merit == `STM_MERIT_UNSYNC && $past(unsync_cnt) == `STM_FAULT_SECONDS - 12'd1)
    else $error("fault without timeout");
  a_alarm_cause: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_hw_fault |=> o_alarm)
    else $error("alarm missed");
  a_quality_char: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    char_idx == 5'd2 |-> next_char == (merit < `STM_MERIT_UNSYNC ? `STM_CH_SP : `STM_CH_QM))
    else $error("bad quality char");
  a_colon_pos: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (char_idx == 5'd10 || char_idx == 5'd13) |-> next_char == `STM_CH_COLON)
    else $error("bad colon");
  a_ends_crlf: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    char_idx == 5'd23 |-> next_char == `STM_CH_CR)
    else $error("bad trailing cr");
  c_msg_done: cover property (@(posedge i_clock) msg_done);
  c_parity: cover property (@(posedge i_clock) tx_state == STM_PARITY);
  c_fault: cover property (@(posedge i_clock) $rose(fault_to));
  c_irq: cover property (@(posedge i_clock) o_irq);
endmodule
`default_nettype wire

// ### design/stm_pkg.sv
// types for the serial time message formatter
package stm_pkg;
  typedef enum logic [2:0] {STM_IDLE, STM_START, STM_DATA, STM_PARITY, STM_STOP} stm_tx_e;
  typedef logic [7:0] stm_char_t;
endpackage

// ### tb/stm_term_model.sv
// serial terminal model that receives and checks time message characters
`timescale 1ns/100ps
`default_nettype none
module stm_term_model #(
  parameter int DIV = 434
) (
  input wire logic i_clock,
  input wire logic i_rxd,
  input wire logic [1:0] i_parity,
  output logic [7:0] o_byte,
  output logic o_valid,
  output logic o_frame_err
);
  logic [7:0] b;
  logic p;
  ////////////////////////////////////////////////////////////////////////
  // sample each bit mid-cell; start edge found on the falling line
  // one process owns the outputs, so each has a single driver
  initial begin
    o_byte = 8'h00;
    o_valid = 1'b0;
    o_frame_err = 1'b0;
    forever begin
      @(negedge i_rxd);
      repeat (DIV / 2) @(posedge i_clock);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge i_clock);
        b[i] = i_rxd;
      end
      if (i_parity == 2'd1 || i_parity == 2'd2) begin
        repeat (DIV) @(posedge i_clock);
        p = i_rxd;
        if ((^{b, p}) !== (i_parity == 2'd1)) o_frame_err <= 1'b1;
      end
      repeat (DIV) @(posedge i_clock);
      if (i_rxd !== 1'b1) o_frame_err <= 1'b1;
      o_byte <= b;
      o_valid <= 1'b1;
      @(posedge i_clock);
      o_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### tb/test_serial_time_message_formatter.sv
// self-checking bench for the serial time message formatter
`timescale 1ns/100ps
`default_nettype none
`include "stm_defines.svh"
module test_serial_time_message_formatter;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic pps = 1'b0, locked = 1'b0, hw_fault = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, o_prdata, q;
  logic o_pready, o_pslverr, o_txd, o_alarm, o_fault_led, o_irq;
  logic [7:0] rx_byte;
  logic rx_valid, rx_err;
  logic [7:0] rx_q[$];
  int n_mismatch = 0, n_tests = 0;
  string exp;
  always #20 i_clock = ~i_clock;
  stm_formatter dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_pps(pps), .i_ref_locked(locked),
    .i_hw_fault(hw_fault), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_txd(o_txd),
    .o_alarm(o_alarm), .o_fault_led(o_fault_led), .o_irq(o_irq));
  stm_term_model #(.DIV(434)) term (.i_clock(i_clock), .i_rxd(o_txd), .i_parity(2'd1),
    .o_byte(rx_byte), .o_valid(rx_valid), .o_frame_err(rx_err));
  always @(posedge i_clock) begin
    if (rx_valid) rx_q.push_back(rx_byte);
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // zero wait states promised, but the loop waits for pready; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (o_pready !== 1'b1);
    q = o_prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_clock);
      pps <= 1'b1;
      @(posedge i_clock);
      pps <= 1'b0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({o_txd, o_alarm, o_fault_led, o_irq}, 4'b1000);
    apb(1'b0, `STM_OFF_STAT, 32'h0);
    chk(q, 32'h09);
    apb(1'b1, 12'h01c, 32'hffff);
    apb(1'b0, 12'h01c, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, `STM_OFF_CTRL, 32'h3f);
    apb(1'b0, `STM_OFF_CTRL, 32'h0);
    chk(q, 32'h33);
    hw_fault <= 1'b1;
    repeat (3) @(posedge i_clock);
    chk(o_alarm, 1'b1);
    hw_fault <= 1'b0;
    repeat (3) @(posedge i_clock);
    chk(o_alarm, 1'b0);
    apb(1'b1, `STM_OFF_IRQ, 32'h7);
    $display("test reset done");
  endtask
  task automatic t_message;
    int n;
    apb(1'b1, `STM_OFF_CTRL, 32'h24);
    apb(1'b1, `STM_OFF_TIME, {7'h0, 9'd366, 5'd23, 6'd59, 5'd0});
    apb(1'b1, `STM_OFF_ZONE, {18'h0, 6'd59, 3'h0, 5'd30});
    apb(1'b1, `STM_OFF_MASK, 32'h1);
    rx_q.delete();
    ticks(1);
    n = 0;
    while (o_txd !== 1'b0 && n < 3) begin
      @(posedge i_clock);
      n++;
    end
    chk(n < 3, 1'b1);
    exp = "\r\n? 366 23:59:59 DTZ=23\r\n";
    n = 0;
    while (rx_q.size() < 25 && n < 130000) begin
      @(posedge i_clock);
      n++;
    end
    chk(rx_q.size(), 25);
    for (int i = 0; i < 25 && i < rx_q.size(); i++) chk(rx_q[i], exp[i]);
    chk(rx_err, 1'b0);
    repeat (500) @(posedge i_clock);
    // the overlapping merit test left alarm and fault events pending and the mask changed
    apb(1'b1, `STM_OFF_MASK, 32'h1);
    apb(1'b0, `STM_OFF_IRQ, 32'h0);
    chk(q, 32'h7);
    @(posedge i_clock);
    chk(o_irq, 1'b1);
    apb(1'b1, `STM_OFF_IRQ, 32'h1);
    @(posedge i_clock);
    chk(o_irq, 1'b0);
    $display("test message done");
  endtask
  task automatic t_merit;
    locked <= 1'b1;
    ticks(3);
    apb(1'b0, `STM_OFF_STAT, 32'h0);
    chk(q, 32'h84);
    apb(1'b1, `STM_OFF_MASK, 32'h2);
    locked <= 1'b0;
    repeat (3) @(posedge i_clock);
    chk({o_alarm, o_irq}, 2'b11);
    ticks(600);
    apb(1'b0, `STM_OFF_STAT, 32'h0);
    chk(q, 32'ha5);
    ticks(2400);
    apb(1'b0, `STM_OFF_STAT, 32'h0);
    chk(q, 32'ha9);
    chk(o_fault_led, 1'b0);
    ticks(3600);
    @(posedge i_clock);
    chk(o_fault_led, 1'b1);
    apb(1'b0, `STM_OFF_FAULT, 32'h0);
    chk(q[0], 1'b1);
    apb(1'b0, `STM_OFF_STAT, 32'h0);
    chk(q, 32'he9);
    $display("test merit done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // a message lasts about 120k cycles; the merit test runs inside it, the rest adds under 2k
  initial begin
    repeat (140000) @(posedge i_clock);
    n_mismatch++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    t_reset();
    // merit test overlaps the long message once the quality character is out
    fork
      t_message();
      begin
        while (rx_q.size() < 3) @(posedge i_clock);
        t_merit();
      end
    join
    stop_test();
  end
endmodule
`default_nettype wire
